// ---- tcic_pkg.sv ----
// Purpose: Constants for the threshold crossing interrupt configuration block
// Assumes: Single clock domain, register port decoded from the serial host port
// Notes: Field layout and codes are shared by the register and the detector
package tcic_pkg;
	localparam int TCIC_ADDR_W = 6;
	localparam int TCIC_DATA_W = 24;
	localparam int TCIC_ADC_W = 10;
	localparam int TCIC_NUM_CH = 4;
	localparam int TCIC_NUM_THR = 3;
	localparam int TCIC_FIELD_W = 6;
	localparam int TCIC_SUB_W = 2;
	localparam int TCIC_EV_W = TCIC_NUM_CH * TCIC_NUM_THR;
	localparam logic [TCIC_ADDR_W-1:0] TCIC_CFG_ADDR = 6'h27;
	localparam logic [TCIC_DATA_W-1:0] TCIC_CFG_RESET = 24'h000000;
	localparam int TCIC_CH18_LSB = 0;
	localparam int TCIC_CH19_LSB = 6;
	localparam int TCIC_CH20_LSB = 12;
	localparam int TCIC_CH21_LSB = 18;
	localparam int TCIC_THR_A = 0;
	localparam int TCIC_THR_B = 1;
	localparam int TCIC_THR_C = 2;
	localparam int TCIC_RISE_BIT = 0;
	localparam int TCIC_FALL_BIT = 1;
	localparam logic [TCIC_SUB_W-1:0] TCIC_SEL_OFF = 2'h0;
	localparam logic [TCIC_SUB_W-1:0] TCIC_SEL_RISE = 2'h1;
	localparam logic [TCIC_SUB_W-1:0] TCIC_SEL_FALL = 2'h2;
	localparam logic [TCIC_SUB_W-1:0] TCIC_SEL_BOTH = 2'h3;
endpackage

// ---- tcic_cfg_reg.sv ----
// Purpose: Holds the crossing interrupt configuration register and its readback
// Assumes: Write and read strobes are one cycle wide and synchronous to clk
// Notes: Unmapped reads return zero
module tcic_cfg_reg
	import tcic_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [TCIC_ADDR_W-1:0] addr,
	input wire logic [TCIC_DATA_W-1:0] wdata,
	// Contents
	output logic [TCIC_DATA_W-1:0] cfg_q,
	output logic [TCIC_DATA_W-1:0] rdata_q
);
	logic hit;

	assign hit = (addr == TCIC_CFG_ADDR);

	// Storage, cleared by reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= TCIC_CFG_RESET; // see R1
		end else if (wr_en && hit) begin
			cfg_q <= wdata; // see R2
		end
	end

	// Readback
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= TCIC_CFG_RESET;
		end else if (rd_en) begin
			rdata_q <= hit ? cfg_q : TCIC_CFG_RESET; // see R2
		end
	end
endmodule

// ---- tcic_crossing_cfg.sv ----
// Purpose: Threshold crossing interrupt configuration and detection, inputs 18 to 21
// Assumes: One conversion result per CONV_VALID pulse, tagged with its channel
// Notes: Events are one-cycle pulses, one cycle after the conversion
// Overview of operation
// R1: Register at 27h, resets to zero
// R2: All fields read back last written value
// R3: Input 21 configuration from bits 23-18
// R4: Input 20 configuration from bits 17-12
// R5: Input 19 configuration from bits 11-6
// R6: Input 18 configuration from bits 5-0
// R7: Low pair selects threshold A edges
// R8: Middle pair selects threshold B edges
// R9: Top pair selects threshold C edges
// R10: Code 00 disables that threshold only
// R11: Code 11 interrupts on either crossing
// R12: Crossing compares previous and current conversion
module tcic_crossing_cfg
	import tcic_pkg::*;
#(
	parameter int ADC_W = TCIC_ADC_W
)
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Register port from the host interface
	input wire logic [TCIC_ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [TCIC_DATA_W-1:0] REG_WDATA,
	output logic [TCIC_DATA_W-1:0] REG_RDATA,
	// Conversion results
	input wire logic CONV_VALID,
	input wire logic [1:0] CONV_CH,
	input wire logic [ADC_W-1:0] CONV_DATA,
	// Threshold levels
	input wire logic [ADC_W-1:0] ADC_LEVEL_GROUP3_A,
	input wire logic [ADC_W-1:0] ADC_LEVEL_GROUP3_B,
	input wire logic [ADC_W-1:0] ADC_LEVEL_GROUP3_C,
	// Crossing events
	output logic [TCIC_EV_W-1:0] CROSS_EVENT,
	output logic CROSS_IRQ
);
	logic [TCIC_DATA_W-1:0] cfg_q;
	logic [TCIC_FIELD_W-1:0] ch18_crossing_irq_sel;
	logic [TCIC_FIELD_W-1:0] ch19_crossing_irq_sel;
	logic [TCIC_FIELD_W-1:0] ch20_crossing_irq_sel;
	logic [TCIC_FIELD_W-1:0] ch21_crossing_irq_sel;
	logic [TCIC_FIELD_W-1:0] sel [TCIC_NUM_CH];
	logic [TCIC_NUM_THR-1:0] above_now;
	logic [TCIC_NUM_THR-1:0] above_q [TCIC_NUM_CH];
	logic [TCIC_NUM_CH-1:0] seen_q;
	logic [TCIC_EV_W-1:0] event_d;
	logic [TCIC_EV_W-1:0] event_q;
	logic irq_q;
	logic wrote_q;

	// Picks the 2-bit code of one threshold from an input's field
	function automatic logic [TCIC_SUB_W-1:0] sub_code(input logic [TCIC_FIELD_W-1:0] f, input int thr);
		sub_code = f[thr*TCIC_SUB_W +: TCIC_SUB_W];
	endfunction

	// Decides whether a transition raises an event under a code
	function automatic logic cross_hit(input logic [TCIC_SUB_W-1:0] code, input logic prev, input logic now);
		cross_hit = (code[TCIC_RISE_BIT] && !prev && now) || (code[TCIC_FALL_BIT] && prev && !now);
	endfunction

	tcic_cfg_reg u_reg (
		.clk(MCLK),
		.rst_n(RESETN),
		.wr_en(REG_WR),
		.rd_en(REG_RD),
		.addr(REG_ADDR),
		.wdata(REG_WDATA),
		.cfg_q(cfg_q),
		.rdata_q(REG_RDATA)
	);

	// Field split per input
	assign ch21_crossing_irq_sel = cfg_q[TCIC_CH21_LSB +: TCIC_FIELD_W]; // see R3
	assign ch20_crossing_irq_sel = cfg_q[TCIC_CH20_LSB +: TCIC_FIELD_W]; // see R4
	assign ch19_crossing_irq_sel = cfg_q[TCIC_CH19_LSB +: TCIC_FIELD_W]; // see R5
	assign ch18_crossing_irq_sel = cfg_q[TCIC_CH18_LSB +: TCIC_FIELD_W]; // see R6
	assign sel[0] = ch18_crossing_irq_sel;
	assign sel[1] = ch19_crossing_irq_sel;
	assign sel[2] = ch20_crossing_irq_sel;
	assign sel[3] = ch21_crossing_irq_sel;

	// Level of the current conversion against each threshold
	assign above_now[TCIC_THR_A] = CONV_DATA > ADC_LEVEL_GROUP3_A;
	assign above_now[TCIC_THR_B] = CONV_DATA > ADC_LEVEL_GROUP3_B;
	assign above_now[TCIC_THR_C] = CONV_DATA > ADC_LEVEL_GROUP3_C;

	// Event decision per input and threshold
	always_comb begin
		event_d = '0;
		for (int ch = 0; ch < TCIC_NUM_CH; ch++) begin
			for (int t = 0; t < TCIC_NUM_THR; t++) begin
				if (CONV_VALID && (CONV_CH == ch[1:0]) && seen_q[ch]) begin
					event_d[ch*TCIC_NUM_THR+t] = cross_hit(sub_code(sel[ch], t), above_q[ch][t], above_now[t]); // see R7 see R8 see R9 see R10 see R11 see R12
				end
			end
		end
	end

	// Previous comparison state per input
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			for (int ch = 0; ch < TCIC_NUM_CH; ch++) begin
				above_q[ch] <= '0;
			end
			seen_q <= '0;
		end else if (CONV_VALID) begin
			above_q[CONV_CH] <= above_now; // see R12
			seen_q[CONV_CH] <= 1'b1;
		end
	end

	// Registered event outputs
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			event_q <= '0;
			irq_q <= 1'b0;
		end else begin
			event_q <= event_d;
			irq_q <= |event_d;
		end
	end

	assign CROSS_EVENT = event_q;
	assign CROSS_IRQ = irq_q;

	// Tracks whether the register was written since reset
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			wrote_q <= 1'b0;
		end else if (REG_WR && REG_ADDR == TCIC_CFG_ADDR) begin
			wrote_q <= 1'b1;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	sequence s_write;
		REG_WR && REG_ADDR == TCIC_CFG_ADDR;
	endsequence

	sequence s_read_only;
		REG_RD && !REG_WR && REG_ADDR == TCIC_CFG_ADDR;
	endsequence

	property p_r1_reset_zero;
		(s_read_only ##0 !wrote_q) |=> REG_RDATA == TCIC_CFG_RESET;
	endproperty
	a_r1_reset_zero: assert property (p_r1_reset_zero) else $error("Read before write not zero"); // see R1

	property p_r2_readback;
		(s_write ##1 s_read_only) |=> REG_RDATA == $past(REG_WDATA, 2);
	endproperty
	a_r2_readback: assert property (p_r2_readback) else $error("Readback differs from write"); // see R2

	property p_r3_ch21;
		s_write |=> ch21_crossing_irq_sel == $past(REG_WDATA[23:18]);
	endproperty
	a_r3_ch21: assert property (p_r3_ch21) else $error("Input 21 field misplaced"); // see R3

	property p_r4_ch20;
		s_write |=> ch20_crossing_irq_sel == $past(REG_WDATA[17:12]);
	endproperty
	a_r4_ch20: assert property (p_r4_ch20) else $error("Input 20 field misplaced"); // see R4

	property p_r5_ch19;
		s_write |=> ch19_crossing_irq_sel == $past(REG_WDATA[11:6]);
	endproperty
	a_r5_ch19: assert property (p_r5_ch19) else $error("Input 19 field misplaced"); // see R5

	property p_r6_ch18;
		s_write |=> ch18_crossing_irq_sel == $past(REG_WDATA[5:0]);
	endproperty
	a_r6_ch18: assert property (p_r6_ch18) else $error("Input 18 field misplaced"); // see R6

	generate
		for (genvar ch = 0; ch < TCIC_NUM_CH; ch++) begin : g_chk
			sequence s_conv;
				CONV_VALID && CONV_CH == ch && seen_q[ch];
			endsequence

			property p_r7_rise_a;
				(s_conv ##0 !above_q[ch][0] && above_now[0] && sel[ch][1:0] == TCIC_SEL_RISE) |=>
					CROSS_EVENT[ch*3] && CROSS_IRQ ##1 (!CROSS_EVENT[ch*3] || $past(CONV_VALID && CONV_CH == ch));
			endproperty
			a_r7_rise_a: assert property (p_r7_rise_a) else $error("Missed rise on A"); // see R7

			property p_r8_fall_b;
				(s_conv ##0 above_q[ch][1] && !above_now[1] && sel[ch][3:2] == TCIC_SEL_FALL) |=>
					CROSS_EVENT[ch*3+1];
			endproperty
			a_r8_fall_b: assert property (p_r8_fall_b) else $error("Missed fall on B"); // see R8

			property p_r9_rise_c_only;
				(s_conv ##0 above_q[ch][2] && !above_now[2] && sel[ch][5:4] == TCIC_SEL_RISE) |=>
					!CROSS_EVENT[ch*3+2];
			endproperty
			a_r9_rise_c_only: assert property (p_r9_rise_c_only) else $error("Fall on C with rise code"); // see R9

			property p_r10_off;
				(sel[ch][1:0] == TCIC_SEL_OFF) |=> !CROSS_EVENT[ch*3];
			endproperty
			a_r10_off: assert property (p_r10_off) else $error("Event on disabled threshold"); // see R10

			property p_r11_both;
				(s_conv ##0 above_q[ch][2] != above_now[2] && sel[ch][5:4] == TCIC_SEL_BOTH) |=>
					CROSS_EVENT[ch*3+2];
			endproperty
			a_r11_both: assert property (p_r11_both) else $error("Missed crossing with both code"); // see R11

			property p_r12_cause;
				CROSS_EVENT[ch*3+1] |-> $past(CONV_VALID && CONV_CH == ch && seen_q[ch]) &&
					$past(above_q[ch][1]) != $past(above_now[1]);
			endproperty
			a_r12_cause: assert property (p_r12_cause) else $error("Event without crossing"); // see R12
		end
	endgenerate
endmodule

// ---- tcic_host_model.sv ----
// Purpose: Host side of the register port
// Assumes: Strobes change at the falling edge of clk
// Notes: Address and data are inverted while idle
module tcic_host_model
	import tcic_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register port
	output logic [TCIC_ADDR_W-1:0] addr,
	output logic wr,
	output logic rd,
	output logic [TCIC_DATA_W-1:0] wdata,
	input wire logic [TCIC_DATA_W-1:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = '0;
		wr = 1'b0;
		rd = 1'b0;
		wdata = '0;
	end
	task automatic wr_reg(input logic [TCIC_ADDR_W-1:0] a, input logic [TCIC_DATA_W-1:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	// Write followed at once by a read of the same address
	task automatic wr_rd_reg(input logic [TCIC_ADDR_W-1:0] a, input logic [TCIC_DATA_W-1:0] d,
		output logic [TCIC_DATA_W-1:0] q);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		addr = ~a;
		wdata = ~d;
		q = rdata;
	endtask
	task automatic rd_reg(input logic [TCIC_ADDR_W-1:0] a, output logic [TCIC_DATA_W-1:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		addr = ~a;
		d = rdata;
	endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the crossing configuration block
// Assumes: Inputs change at the falling edge of MCLK
// Notes: Levels A, B, C are fixed at 100, 200, 300
module tb_top
	import tcic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, resetn, cv, irq, wr, rd;
	logic [1:0] cch;
	logic [9:0] cdat;
	logic [5:0] addr;
	logic [23:0] wdata, rdata;
	logic [11:0] ev;
	int bad_count, n_checks;
	tcic_host_model host (.clk(mclk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
	tcic_crossing_cfg #(.ADC_W(10)) uut (.MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr), .REG_WR(wr),
		.REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .CONV_VALID(cv), .CONV_CH(cch),
		.CONV_DATA(cdat), .ADC_LEVEL_GROUP3_A(10'h064), .ADC_LEVEL_GROUP3_B(10'h0c8),
		.ADC_LEVEL_GROUP3_C(10'h12c), .CROSS_EVENT(ev), .CROSS_IRQ(irq));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkev(input logic [12:0] got, input logic [12:0] exp);
		chk24({11'h000, got}, {11'h000, exp});
	endtask
	// Conversion pulse, then events and irq after the taking edge
	task automatic conv(input logic [1:0] ch, input logic [9:0] d, input logic [11:0] exp);
		@(negedge mclk);
		cv = 1'b1;
		cch = ch;
		cdat = d;
		@(negedge mclk);
		cv = 1'b0;
		cdat = ~d;
		chkev({irq, ev}, {|exp, exp});
	endtask
	initial begin
		#500000;
		bad_count++;
		close_out();
	end
	initial begin
		logic [23:0] r;
		logic [11:0] e;
		cv = 1'b0;
		cch = 2'h0;
		cdat = 10'h000;
		resetn = 1'b0;
		repeat (10) @(negedge mclk);
		resetn = 1'b1;
		host.rd_reg(TCIC_CFG_ADDR, r);
		chk24(r, TCIC_CFG_RESET);
		host.wr_reg(TCIC_CFG_ADDR, 24'ha5c3f0);
		host.wr_reg(6'h28, 24'h123456);
		host.rd_reg(TCIC_CFG_ADDR, r);
		chk24(r, 24'ha5c3f0);
		host.rd_reg(6'h26, r);
		chk24(r, 24'h000000);
		$display("test registers done");
		host.wr_reg(TCIC_CFG_ADDR, 24'hffffff);
		for (int ch = 0; ch < 4; ch++) begin
			conv(ch[1:0], 10'h3ff, 12'h000);
		end
		for (int ch = 0; ch < 4; ch++) begin
			conv(ch[1:0], 10'h000, 12'h007 << (ch * 3));
		end
		$display("test first conversion done");
		for (int ch = 0; ch < 4; ch++) begin
			for (int t = 0; t < 3; t++) begin
				for (int c = 1; c < 4; c++) begin
					host.wr_reg(TCIC_CFG_ADDR, 24'(c) << (ch * 6 + t * 2));
					e = 12'h001 << (ch * 3 + t);
					conv(ch[1:0], 10'h3ff, c[0] ? e : 12'h000);
					conv(ch[1:0], 10'h000, c[1] ? e : 12'h000);
				end
			end
		end
		$display("test field map done");
		host.wr_reg(TCIC_CFG_ADDR, 24'h000003);
		conv(2'h0, 10'h064, 12'h000);
		conv(2'h0, 10'h065, 12'h001);
		conv(2'h0, 10'h064, 12'h001);
		$display("test boundary done");
		host.wr_rd_reg(TCIC_CFG_ADDR, 24'h3c0f5a, r);
		chk24(r, 24'h3c0f5a);
		@(negedge mclk);
		resetn = 1'b0;
		repeat (2) @(negedge mclk);
		resetn = 1'b1;
		host.rd_reg(TCIC_CFG_ADDR, r);
		chk24(r, TCIC_CFG_RESET);
		host.wr_reg(TCIC_CFG_ADDR, 24'hffffff);
		conv(2'h0, 10'h3ff, 12'h000);
		conv(2'h0, 10'h000, 12'h007);
		$display("test mid-run reset done");
		close_out();
	end
endmodule
